// *** hdl/ictim_pkg.sv ***
/*
 * Package for the instruction cycle timing block: operation codes,
 * operand forms, bus-width variants and all clock-count figures.
 * Assumes nothing of its surroundings beyond a single processor clock.
 */
package ictim_pkg;

    typedef enum logic [3:0] {
        OP_SHIFT_LEFT_ONE = 4'h0,
        OP_SHIFT_LEFT_CNT = 4'h1,
        OP_SHIFT_RIGHT_ONE = 4'h2,
        OP_SHIFT_RIGHT_CNT = 4'h3,
        OP_SHIFT_RIGHT_IMM = 4'h4,
        OP_SUB_IMM_ACC = 4'h5,
        OP_SUB_IMM_RM = 4'h6,
        OP_SUB_REG_RM = 4'h7,
        OP_STRING_STORE = 4'h8,
        OP_TEST_IMM_ACC = 4'h9,
        OP_TEST_IMM_RM = 4'hA,
        OP_TEST_REG_RM = 4'hB,
        OP_EXCH_ACC = 4'hC,
        OP_EXCH_REG_RM = 4'hD,
        OP_XOR_IMM_ACC = 4'hE,
        OP_XOR_IMM_RM = 4'hF
    } ictim_op_e;

    // the register/memory xor form has no free 4-bit code, so a fifth bit selects it
    localparam logic [4:0] OP_XOR_REG_RM = 5'h10;
    localparam int OP_W = 5;
    localparam int CYC_W = 8;
    localparam int CNT_W = 16;
    localparam int TOT_W = 20;

    // per-variant pair: register form, memory form
    typedef struct packed {
        logic [CYC_W-1:0] reg_cyc;
        logic [CYC_W-1:0] mem_cyc;
    } ictim_pair_s;

    localparam logic [CYC_W-1:0] C1 = 8'h01;
    localparam logic [CYC_W-1:0] C2 = 8'h02;
    localparam logic [CYC_W-1:0] C3 = 8'h03;

    // wide-bus figures, memory form except W_LEFT_ONE and the string pair, which serve both forms; left and right are the logical shifts
    localparam logic [CYC_W-1:0] W_LEFT_ONE = 8'h05;
    localparam logic [CYC_W-1:0] W_LEFT_CNT = 8'h14;
    localparam logic [CYC_W-1:0] W_RIGHT_ONE = 8'h05;
    localparam logic [CYC_W-1:0] W_RIGHT_CNT = 8'h14;
    localparam logic [CYC_W-1:0] W_RIGHT_IMM = 8'h0B;
    localparam logic [CYC_W-1:0] W_SUB_IMM = 8'h0B;
    localparam logic [CYC_W-1:0] W_SUB_REG = 8'h0F;
    localparam logic [CYC_W-1:0] W_TEST_IMM = 8'h10;
    localparam logic [CYC_W-1:0] W_TEST_REG = 8'h0C;
    localparam logic [CYC_W-1:0] W_EXCH = 8'h10;
    localparam logic [CYC_W-1:0] W_XOR_IMM = 8'h0B;
    localparam logic [CYC_W-1:0] W_XOR_REG = 8'h10;
    localparam logic [CYC_W-1:0] W_STR_BASE = 8'h06;
    localparam logic [CYC_W-1:0] W_STR_EACH = 8'h04;

    // narrow-bus figures: memory forms, and both forms of the string store
    localparam logic [CYC_W-1:0] N_LEFT_ONE = 8'h20;
    localparam logic [CYC_W-1:0] N_LEFT_CNT = 8'h18;
    localparam logic [CYC_W-1:0] N_RIGHT_ONE = 8'h18;
    localparam logic [CYC_W-1:0] N_RIGHT_CNT = 8'h1C;
    localparam logic [CYC_W-1:0] N_RIGHT_IMM = 8'h18;
    localparam logic [CYC_W-1:0] N_SUB_IMM = 8'h1C;
    localparam logic [CYC_W-1:0] N_SUB_REG = 8'h28;
    localparam logic [CYC_W-1:0] N_TEST_IMM = 8'h10;
    localparam logic [CYC_W-1:0] N_TEST_REG = 8'h14;
    localparam logic [CYC_W-1:0] N_EXCH = 8'h14;
    localparam logic [CYC_W-1:0] N_XOR_IMM = 8'h20;
    localparam logic [CYC_W-1:0] N_XOR_REG = 8'h20;
    localparam logic [CYC_W-1:0] N_STR_BASE = 8'h08;
    localparam logic [CYC_W-1:0] N_STR_EACH = 8'h08;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_BUSY = 2'b01,
        ST_DONE = 2'b10
    } ictim_state_e;

endpackage

// *** hdl/ictim_table.sv ***
/*
 * Combinational table of execution clocks per operation and variant.
 * Assumes the caller selects register or memory form and bus width.
 */
module ictim_table (
    // request
    input wire logic [ictim_pkg::OP_W-1:0] op_in,
    input wire logic mem_in,
    input wire logic narrow_in,
    input wire logic [ictim_pkg::CNT_W-1:0] count_in,
    // result
    output logic [ictim_pkg::TOT_W-1:0] cycles_out,
    output logic legal_out
);

    function automatic logic [ictim_pkg::CYC_W-1:0] pick(
        input logic narrow,
        input logic mem,
        input logic [ictim_pkg::CYC_W-1:0] reg_cyc,
        input logic [ictim_pkg::CYC_W-1:0] wide_mem,
        input logic [ictim_pkg::CYC_W-1:0] narrow_mem
    );
        logic [ictim_pkg::CYC_W-1:0] r;
        r = reg_cyc;
        if (mem) begin
            r = narrow ? narrow_mem : wide_mem;
        end
        return r;
    endfunction

    logic [ictim_pkg::CYC_W-1:0] base;
    logic [ictim_pkg::CYC_W-1:0] each;
    logic [ictim_pkg::TOT_W-1:0] prod;

    always_comb begin
        base = ictim_pkg::C1;
        each = '0;
        legal_out = 1'b1;
        if (op_in == ictim_pkg::OP_XOR_REG_RM) begin
            base = pick(narrow_in, mem_in, ictim_pkg::C1, ictim_pkg::W_XOR_REG,
                        ictim_pkg::N_XOR_REG);
        end else if (op_in[4]) begin
            legal_out = 1'b0;
        end else begin
            unique case (ictim_pkg::ictim_op_e'(op_in[3:0]))
                ictim_pkg::OP_SHIFT_LEFT_ONE: begin
                    base = pick(narrow_in, mem_in, ictim_pkg::C1, ictim_pkg::W_LEFT_ONE,
                                ictim_pkg::N_LEFT_ONE);
                    if (!narrow_in) begin
                        base = ictim_pkg::W_LEFT_ONE;
                    end
                end
                ictim_pkg::OP_SHIFT_LEFT_CNT: begin
                    base = pick(narrow_in, mem_in, ictim_pkg::C1, ictim_pkg::W_LEFT_CNT,
                                ictim_pkg::N_LEFT_CNT);
                end
                ictim_pkg::OP_SHIFT_RIGHT_ONE: begin
                    base = pick(narrow_in, mem_in, ictim_pkg::C1, ictim_pkg::W_RIGHT_ONE,
                                ictim_pkg::N_RIGHT_ONE);
                end
                ictim_pkg::OP_SHIFT_RIGHT_CNT: begin
                    base = pick(narrow_in, mem_in, ictim_pkg::C1, ictim_pkg::W_RIGHT_CNT,
                                ictim_pkg::N_RIGHT_CNT);
                end
                ictim_pkg::OP_SHIFT_RIGHT_IMM: begin
                    base = pick(narrow_in, mem_in, ictim_pkg::C1, ictim_pkg::W_RIGHT_IMM,
                                ictim_pkg::N_RIGHT_IMM);
                end
                ictim_pkg::OP_SUB_IMM_ACC: begin
                    base = ictim_pkg::C1;
                end
                ictim_pkg::OP_SUB_IMM_RM: begin
                    base = pick(narrow_in, mem_in, ictim_pkg::C1, ictim_pkg::W_SUB_IMM,
                                ictim_pkg::N_SUB_IMM);
                end
                ictim_pkg::OP_SUB_REG_RM: begin
                    base = pick(narrow_in, mem_in, ictim_pkg::C1, ictim_pkg::W_SUB_REG,
                                ictim_pkg::N_SUB_REG);
                end
                ictim_pkg::OP_STRING_STORE: begin
                    base = narrow_in ? ictim_pkg::N_STR_BASE : ictim_pkg::W_STR_BASE;
                    each = narrow_in ? ictim_pkg::N_STR_EACH : ictim_pkg::W_STR_EACH;
                end
                ictim_pkg::OP_TEST_IMM_ACC: begin
                    base = ictim_pkg::C1;
                end
                ictim_pkg::OP_TEST_IMM_RM: begin
                    base = pick(narrow_in, mem_in, ictim_pkg::C1, ictim_pkg::W_TEST_IMM,
                                ictim_pkg::N_TEST_IMM);
                end
                ictim_pkg::OP_TEST_REG_RM: begin
                    base = pick(narrow_in, mem_in, ictim_pkg::C1, ictim_pkg::W_TEST_REG,
                                ictim_pkg::N_TEST_REG);
                end
                ictim_pkg::OP_EXCH_ACC: begin
                    base = ictim_pkg::C2;
                end
                ictim_pkg::OP_EXCH_REG_RM: begin
                    base = pick(narrow_in, mem_in, ictim_pkg::C3, ictim_pkg::W_EXCH,
                                ictim_pkg::N_EXCH);
                end
                ictim_pkg::OP_XOR_IMM_ACC: begin
                    base = ictim_pkg::C1;
                end
                ictim_pkg::OP_XOR_IMM_RM: begin
                    base = pick(narrow_in, mem_in, ictim_pkg::C1, ictim_pkg::W_XOR_IMM,
                                ictim_pkg::N_XOR_IMM);
                end
            endcase
        end
        prod = ictim_pkg::TOT_W'({4'h0, count_in} * {12'h000, each});
        cycles_out = ictim_pkg::TOT_W'({12'h000, base}) + prod;
    end

endmodule

// *** hdl/ictim_core.sv ***
/*
 * Execution timing sequencer: takes one instruction request, looks up
 * its clock count and holds busy for exactly that many clocks, then
 * pulses done. Assumes requests come from logic on the same clock.
 */
module ictim_core (
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // request
    input wire logic start_in,
    input wire logic [ictim_pkg::OP_W-1:0] op_in,
    input wire logic mem_operand_in,
    input wire logic narrow_bus_in,
    input wire logic [ictim_pkg::CNT_W-1:0] repeat_count_in,
    // status
    output logic busy_out,
    output logic done_out,
    output logic illegal_out,
    output logic [ictim_pkg::TOT_W-1:0] cycles_out
);

    typedef struct packed {
        ictim_pkg::ictim_state_e state;
        logic [ictim_pkg::TOT_W-1:0] remain;
        logic [ictim_pkg::TOT_W-1:0] cycles;
        logic busy;
        logic done;
        logic illegal;
    } ictim_core_s;

    ictim_core_s st_r;
    ictim_core_s st_nxt;

    logic [ictim_pkg::TOT_W-1:0] lookup_cycles;
    logic lookup_legal;

    ictim_table u_table (
        .op_in(op_in),
        .mem_in(mem_operand_in),
        .narrow_in(narrow_bus_in),
        .count_in(repeat_count_in),
        .cycles_out(lookup_cycles),
        .legal_out(lookup_legal)
    );

    localparam logic [ictim_pkg::TOT_W-1:0] ONE = 20'h00001;

    always_comb begin
        st_nxt = st_r;
        st_nxt.done = 1'b0;
        st_nxt.illegal = 1'b0;
        unique case (st_r.state)
            ictim_pkg::ST_IDLE, ictim_pkg::ST_DONE: begin
                st_nxt.state = ictim_pkg::ST_IDLE;
                if (start_in) begin
                    if (!lookup_legal) begin
                        st_nxt.illegal = 1'b1;
                    end else begin
                        // busy stands for exactly the looked-up number of clocks
                        st_nxt.cycles = lookup_cycles;
                        st_nxt.remain = lookup_cycles - ONE;
                        st_nxt.busy = 1'b1;
                        st_nxt.state = ictim_pkg::ST_BUSY;
                    end
                end
            end
            ictim_pkg::ST_BUSY: begin
                if (st_r.remain == '0) begin
                    st_nxt.busy = 1'b0;
                    st_nxt.done = 1'b1;
                    st_nxt.state = ictim_pkg::ST_DONE;
                end else begin
                    st_nxt.remain = st_r.remain - ONE;
                end
            end
            default: begin
                st_nxt.state = ictim_pkg::ST_IDLE;
                st_nxt.busy = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            st_r <= '{state: ictim_pkg::ST_IDLE, remain: '0, cycles: '0,
                      busy: 1'b0, done: 1'b0, illegal: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign busy_out = st_r.busy;
    assign done_out = st_r.done;
    assign illegal_out = st_r.illegal;
    assign cycles_out = st_r.cycles;

endmodule

// *** tb/ictim_core_assertions.sv ***
/*
 * Concurrent checks on the ports of the execution timing sequencer.
 * Assumes one clock, asynchronous active-low reset, bound to ictim_core.
 */
module ictim_core_assertions (
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // request
    input wire logic start_in,
    input wire logic [ictim_pkg::OP_W-1:0] op_in,
    input wire logic mem_operand_in,
    input wire logic narrow_bus_in,
    input wire logic [ictim_pkg::CNT_W-1:0] repeat_count_in,
    // status
    input wire logic busy_out,
    input wire logic done_out,
    input wire logic illegal_out,
    input wire logic [ictim_pkg::TOT_W-1:0] cycles_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    logic take;
    logic [19:0] run_r;
    assign take = start_in && !busy_out;

    // length of the current busy stretch
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            run_r <= 20'h00000;
        end else if (busy_out) begin
            run_r <= run_r + 20'h00001;
        end else begin
            run_r <= 20'h00000;
        end
    end

    start_busy_a: assert property (take && op_in <= 5'h10 |=> busy_out)
        else $error("legal start did not raise busy");
    illegal_pulse_a: assert property (take && op_in > 5'h10 |=> illegal_out && !busy_out ##1 !illegal_out)
        else $error("illegal code not flagged once");
    done_after_a: assert property ($fell(busy_out) |-> done_out)
        else $error("done missing after busy");
    busy_len_a: assert property ($fell(busy_out) |-> run_r == cycles_out)
        else $error("busy length differs from figure");
    acc_one_a: assert property (take && op_in inside {5'h05, 5'h09, 5'h0E} |=> busy_out ##1 !busy_out)
        else $error("accumulator form not one clock");
    exch_acc_a: assert property (take && op_in == 5'h0C |=> busy_out [*2] ##1 !busy_out)
        else $error("exchange with accumulator not two clocks");
    exch_reg_a: assert property (take && op_in == 5'h0D && !mem_operand_in |=> busy_out [*3] ##1 !busy_out)
        else $error("register exchange not three clocks");
    test_mem_a: assert property (take && op_in == 5'h0A && mem_operand_in |=> cycles_out == 20'h00010)
        else $error("test immediate memory figure wrong");
    str_wide_a: assert property (take && op_in == 5'h08 && !narrow_bus_in
        |=> cycles_out == {2'b00, $past(repeat_count_in), 2'b00} + 20'h00006)
        else $error("wide string store figure wrong");
    str_narrow_a: assert property (take && op_in == 5'h08 && narrow_bus_in
        |=> cycles_out == {1'b0, $past(repeat_count_in), 3'b000} + 20'h00008)
        else $error("narrow string store figure wrong");
    sub_narrow_a: assert property (take && op_in == 5'h07 && narrow_bus_in && mem_operand_in
        |=> cycles_out == 20'h00028)
        else $error("narrow subtract memory figure wrong");

    cover property (take && op_in == 5'h08);
    cover property ($fell(busy_out));
    cover property (illegal_out);
endmodule

bind ictim_core ictim_core_assertions u_chk (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .start_in(start_in), .op_in(op_in), .mem_operand_in(mem_operand_in),
    .narrow_bus_in(narrow_bus_in), .repeat_count_in(repeat_count_in), .busy_out(busy_out),
    .done_out(done_out), .illegal_out(illegal_out), .cycles_out(cycles_out));

// *** tb/ictim_core_tb.sv ***
/*
 * Self-checking bench for the execution timing sequencer.
 * Assumes the block takes one start at a time and reports through busy and done.
 */
module ictim_core_tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic start_in = 1'b0;
    logic [4:0] op_in = 5'h00;
    logic mem_operand_in = 1'b0;
    logic narrow_bus_in = 1'b0;
    logic [15:0] repeat_count_in = 16'h0000;
    logic busy_out;
    logic done_out;
    logic illegal_out;
    logic [19:0] cycles_out;
    int num_errors = 0;
    int check_count = 0;

    // per op: wide register, wide memory, narrow register, narrow memory
    localparam logic [7:0] WR [17] = '{8'h05, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01,
        8'h06, 8'h01, 8'h01, 8'h01, 8'h02, 8'h03, 8'h01, 8'h01, 8'h01};
    localparam logic [7:0] WM [17] = '{8'h05, 8'h14, 8'h05, 8'h14, 8'h0B, 8'h01, 8'h0B, 8'h0F,
        8'h06, 8'h01, 8'h10, 8'h0C, 8'h02, 8'h10, 8'h01, 8'h0B, 8'h10};
    localparam logic [7:0] NR [17] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01,
        8'h08, 8'h01, 8'h01, 8'h01, 8'h02, 8'h03, 8'h01, 8'h01, 8'h01};
    localparam logic [7:0] NM [17] = '{8'h20, 8'h18, 8'h18, 8'h1C, 8'h18, 8'h01, 8'h1C, 8'h28,
        8'h08, 8'h01, 8'h10, 8'h14, 8'h02, 8'h14, 8'h01, 8'h20, 8'h20};

    always #25 clk_in = ~clk_in;

    ictim_core dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .start_in(start_in),
        .op_in(op_in), .mem_operand_in(mem_operand_in), .narrow_bus_in(narrow_bus_in),
        .repeat_count_in(repeat_count_in), .busy_out(busy_out), .done_out(done_out),
        .illegal_out(illegal_out), .cycles_out(cycles_out));

    task automatic test_done();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check_val(input logic [19:0] got, input logic [19:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s got %0d expected %0d", $time, what, got, exp);
        end
    endtask

    task automatic check_flag(input logic got, input logic exp, input string what);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    // one request; poke holds start into the busy cycle with another op
    task automatic run_op(input logic [4:0] op, input logic mem, input logic nar,
        input logic [15:0] n, input logic [19:0] exp, input logic poke);
        int cnt;
        int k;
        logic seen;
        cnt = 0;
        seen = 1'b0;
        @(posedge clk_in);
        start_in <= 1'b1;
        op_in <= op;
        mem_operand_in <= mem;
        narrow_bus_in <= nar;
        repeat_count_in <= n;
        @(posedge clk_in);
        start_in <= poke;
        if (poke) begin
            op_in <= 5'h07;
        end
        for (k = 0; k < 2000 && !seen; k++) begin
            @(negedge clk_in);
            if (busy_out === 1'b1) begin
                cnt++;
            end else begin
                check_flag(done_out, 1'b1, "done after busy");
                seen = 1'b1;
            end
            @(posedge clk_in);
            start_in <= 1'b0;
        end
        if (!seen) begin
            num_errors++;
            $display("CHECK FAILED at %0t: no done", $time);
            test_done();
        end else begin
            @(negedge clk_in);
            check_flag(done_out, 1'b0, "done width");
            check_val(cnt[19:0], exp, "busy clocks");
            check_val(cycles_out, exp, "cycles figure");
        end
    endtask

    task automatic test_table();
        int op;
        int v;
        logic [19:0] exp;
        for (op = 0; op < 17; op++) begin
            for (v = 0; v < 4; v++) begin
                exp = {12'h000, v == 0 ? WR[op] : v == 1 ? WM[op] : v == 2 ? NR[op] : NM[op]};
                run_op(op[4:0], v[0], v[1], 16'h0000, exp, 1'b0);
            end
        end
        $display("test table done");
    endtask

    task automatic test_string();
        run_op(5'h08, 1'b1, 1'b0, 16'h0001, 20'h00006 + 20'h00004, 1'b0);
        run_op(5'h08, 1'b0, 1'b0, 16'h0019, 20'h00006 + 20'h00064, 1'b0);
        run_op(5'h08, 1'b0, 1'b1, 16'h0019, 20'h00008 + 20'h000C8, 1'b0);
        $display("test string done");
    endtask

    task automatic test_refused();
        run_op(5'h0C, 1'b0, 1'b0, 16'h0000, 20'h00002, 1'b1);
        @(posedge clk_in);
        start_in <= 1'b1;
        op_in <= 5'h11;
        @(posedge clk_in);
        start_in <= 1'b0;
        @(negedge clk_in);
        check_flag(illegal_out, 1'b1, "illegal pulse");
        check_flag(busy_out, 1'b0, "busy on illegal");
        @(negedge clk_in);
        check_flag(illegal_out, 1'b0, "illegal width");
        check_val(cycles_out, 20'h00002, "figure kept");
        $display("test refused done");
    endtask

    task automatic test_reset();
        @(posedge clk_in);
        start_in <= 1'b1;
        op_in <= 5'h07;
        mem_operand_in <= 1'b1;
        narrow_bus_in <= 1'b1;
        @(posedge clk_in);
        start_in <= 1'b0;
        repeat (5) @(posedge clk_in);
        reset_n_in <= 1'b0;
        @(negedge clk_in);
        check_flag(busy_out, 1'b0, "busy in reset");
        check_flag(done_out, 1'b0, "done in reset");
        check_val(cycles_out, 20'h00000, "figure in reset");
        @(posedge clk_in);
        reset_n_in <= 1'b1;
        run_op(5'h0D, 1'b1, 1'b1, 16'h0000, 20'h00014, 1'b0);
        $display("test reset done");
    endtask

    initial begin
        repeat (20) @(posedge clk_in);
        reset_n_in <= 1'b1;
        test_table();
        test_string();
        test_refused();
        test_reset();
        test_done();
    end
endmodule
